// file: hw/cfel_dev.sv
// The AHB-Lite register port and the address map were left to the implementer.
`timescale 1ns/10ps
`include "cfel_defines.svh"
module cfel_dev #(
  parameter int TMO_CYC = `CFEL_FILL_TMO_CYC
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  input  wire logic        rmw_valid,
  input  wire logic        rmw_uncorr,
  input  wire logic        rmw_bad_addr,
  input  wire logic [31:0] rmw_addr,
  input  wire logic [7:0]  rmw_check,
  input  wire logic        ownership_read_start,
  input  wire logic [3:0]  ownership_read_tid,
  input  wire logic [31:0] ownership_read_addr,
  output logic             wb_valid,
  output logic [7:0]       wb_check,
  output logic             blk_inval,
  output logic [31:0]      blk_inval_addr,
  output logic             fill_word_valid,
  output logic [63:0]      fill_word,
  output logic             ownership_read_busy,
  output logic             error_transition_mode,
  output logic             hard_err_req,
  output logic [4:0]       hard_err_ipl,
  output logic [11:0]      hard_err_vector,
  output logic             irq,
  cfel_if.dev              link
);

  // The timeout counter is 16 bits wide, so longer limits cannot be served.
  if (TMO_CYC < 1 || TMO_CYC > 65535)
  begin : g_tmo_range
    $error("cfel_dev: TMO_CYC out of range");
  end

  localparam logic [15:0] TMO_LAST = 16'(TMO_CYC - 1);

  cfel_pkg::cfel_dev_s r;
  cfel_pkg::cfel_dev_s next_r;

  ////////////////////////////////////////////////////////////////////////////
  // Outputs from flip-flops or constants, except error_transition_mode, which is the OR of hw_tm and sw_tm.
  assign hreadyout             = r.hrdy;
  assign hresp                 = 1'b0;
  assign hrdata                = r.hrdata;
  assign wb_valid              = r.wb_valid;
  assign wb_check              = r.wb_check;
  assign blk_inval             = r.inval;
  assign blk_inval_addr        = r.inval_addr;
  assign fill_word_valid       = r.fw_valid;
  assign fill_word             = r.fw_data;
  assign ownership_read_busy            = (r.rd == cfel_pkg::RD_WAIT);
  assign error_transition_mode = r.hw_tm | r.sw_tm;
  assign hard_err_req          = r.hard_err;
  assign hard_err_ipl          = `CFEL_HERR_IPL;
  assign hard_err_vector       = `CFEL_HERR_VECTOR;
  assign irq                   = r.irq;
  assign link.req              = r.req;
  assign link.req_tid          = r.tid;
  assign link.req_addr         = r.rd_addr;

  function automatic logic [31:0] read_mux(input cfel_pkg::cfel_dev_s s, input logic [7:0] a);
    logic [31:0] v;
    v = 32'h0000_0000;
    case (a)
      `CFEL_OFS_DATA_ERR:  v = {28'h000_0000, s.de_lock, s.de_lost, s.de_bad_addr, s.de_uncorr};
      `CFEL_OFS_FILL_ERR:  v = {25'h000_0000, s.fe_cnt, s.fe_lock, s.fe_lost, s.fe_unexp, s.fe_timeout, s.fe_rde};
      `CFEL_OFS_FILL_ADDR: v = s.fe_addr;
      `CFEL_OFS_CTRL:      v = {30'h0000_0000, s.sw_tm, s.hw_tm};
      `CFEL_OFS_IRQ_STS:   v = {28'h000_0000, s.irq_sts};
      `CFEL_OFS_IRQ_EN:    v = {28'h000_0000, s.irq_en};
      `CFEL_OFS_DATA_ADDR: v = s.de_addr;
      default:             v = 32'h0000_0000;
    endcase
    return v;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // One wait state per transfer lets read data come from a flop.
  logic       fill_err;
  logic       fill_unexp;
  logic [3:0] irq_set;

  always_comb
  begin
    next_r          = r;
    next_r.req      = 1'b0;
    next_r.wb_valid = 1'b0;
    next_r.inval    = 1'b0;
    next_r.fw_valid = 1'b0;
    fill_err        = 1'b0;
    fill_unexp      = 1'b0;
    irq_set         = 4'h0;

    // Bus slave.
    if (r.dp)
    begin
      next_r.dp   = 1'b0;
      next_r.hrdy = 1'b1;
      if (!r.dp_wr)
        next_r.hrdata = read_mux(r, r.dp_addr);
      else
        // Clears go first so that an event in the same cycle wins below.
        unique case (r.dp_addr)
          `CFEL_OFS_DATA_ERR:
          begin
            next_r.de_uncorr   = r.de_uncorr & ~hwdata[`CFEL_DE_UNCORR];
            next_r.de_bad_addr = r.de_bad_addr & ~hwdata[`CFEL_DE_BAD_ADDR];
            next_r.de_lost     = r.de_lost & ~hwdata[`CFEL_DE_LOST];
            next_r.de_lock     = r.de_lock & ~hwdata[`CFEL_DE_LOCK];
          end
          `CFEL_OFS_FILL_ERR:
          begin
            next_r.fe_rde     = r.fe_rde & ~hwdata[`CFEL_FE_RDE];
            next_r.fe_timeout = r.fe_timeout & ~hwdata[`CFEL_FE_TIMEOUT];
            next_r.fe_unexp   = r.fe_unexp & ~hwdata[`CFEL_FE_UNEXP];
            next_r.fe_lost    = r.fe_lost & ~hwdata[`CFEL_FE_LOST];
            next_r.fe_lock    = r.fe_lock & ~hwdata[`CFEL_FE_LOCK];
          end
          `CFEL_OFS_CTRL:
          begin
            next_r.hw_tm = r.hw_tm & ~hwdata[`CFEL_CT_HW_TM];
            next_r.sw_tm = hwdata[`CFEL_CT_SW_TM];
          end
          `CFEL_OFS_IRQ_CLR: next_r.irq_sts = r.irq_sts & ~hwdata[3:0];
          `CFEL_OFS_IRQ_EN:  next_r.irq_en = hwdata[3:0];
          default:
          begin
          end
        endcase
    end
    else if (hsel && htrans[1] && hready)
    begin
      next_r.dp      = 1'b1;
      next_r.hrdy    = 1'b0;
      next_r.dp_wr   = hwrite;
      next_r.dp_addr = haddr[7:0];
    end

    // Read-modify-write writeback.
    if (rmw_valid)
    begin
      next_r.wb_valid = 1'b1;
      next_r.wb_check = rmw_check;
      if (rmw_uncorr || rmw_bad_addr)
      begin
        next_r.wb_check = rmw_check ^ `CFEL_CHECK_INV;
        next_r.hw_tm    = 1'b1;
        irq_set[`CFEL_IRQ_DATA] = 1'b1;
        if (r.de_lock)
        begin
          next_r.de_lost = 1'b1;
          irq_set[`CFEL_IRQ_LOST] = 1'b1;
        end
        else
        begin
          next_r.de_uncorr   = rmw_uncorr;
          next_r.de_bad_addr = rmw_bad_addr;
          next_r.de_lock     = 1'b1;
          next_r.de_addr     = rmw_addr;
        end
      end
    end

    // Ownership read tracking.
    unique case (r.rd)
      cfel_pkg::RD_IDLE:
      begin
        if (ownership_read_start)
        begin
          next_r.rd      = cfel_pkg::RD_WAIT;
          next_r.req     = 1'b1;
          next_r.tid     = ownership_read_tid;
          next_r.rd_addr = ownership_read_addr;
          next_r.words   = 3'h0;
          next_r.tmo     = 16'h0000;
        end
      end
      cfel_pkg::RD_WAIT:
      begin
        next_r.tmo = r.tmo + 16'h0001;
        if (link.fill_valid && link.fill_tid == r.tid)
        begin
          if (link.fill_rde)
          begin
            next_r.rd = cfel_pkg::RD_IDLE;
            fill_err  = (r.words != 3'h0);
          end
          else
          begin
            next_r.fw_valid = 1'b1;
            next_r.fw_data  = link.fill_data;
            next_r.words    = r.words + 3'h1;
            next_r.tmo      = 16'h0000;
            if (r.words == `CFEL_LAST_WORD)
              next_r.rd = cfel_pkg::RD_IDLE;
          end
        end
        else if (r.tmo == TMO_LAST)
        begin
          next_r.rd = cfel_pkg::RD_IDLE;
          fill_err  = (r.words != 3'h0);
        end
      end
    endcase

    if (link.fill_valid && (r.rd == cfel_pkg::RD_IDLE || link.fill_tid != r.tid))
      fill_unexp = 1'b1;

    if (fill_err)
    begin
      next_r.inval      = 1'b1;
      next_r.inval_addr = r.rd_addr;
      next_r.hw_tm      = 1'b1;
      irq_set[`CFEL_IRQ_FILL] = 1'b1;
    end
    if (fill_unexp)
    begin
      next_r.hw_tm = 1'b1;
      irq_set[`CFEL_IRQ_UNEXP] = 1'b1;
    end
    if (fill_err || fill_unexp)
    begin
      if (r.fe_lock)
      begin
        next_r.fe_lost = 1'b1;
        irq_set[`CFEL_IRQ_LOST] = 1'b1;
      end
      else
      begin
        next_r.fe_lock = 1'b1;
        if (fill_err)
        begin
          next_r.fe_rde     = link.fill_rde && link.fill_valid;
          next_r.fe_timeout = !(link.fill_rde && link.fill_valid);
          next_r.fe_cnt     = r.words[1:0];
          next_r.fe_addr    = r.rd_addr;
        end
        else
        begin
          next_r.fe_unexp = 1'b1;
          next_r.fe_rde   = link.fill_rde;
        end
      end
    end

    next_r.irq_sts  = next_r.irq_sts | irq_set;
    next_r.irq      = |(next_r.irq_sts & next_r.irq_en);
    next_r.hard_err = next_r.de_lock | next_r.de_lost | next_r.fe_lock | next_r.fe_lost;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      r      <= '0;
      r.hrdy <= 1'b1;
      r.rd   <= cfel_pkg::RD_IDLE;
    end
    else
      r <= next_r;
  end

endmodule // cfel_dev

// file: hw/cfel_defines.svh
`ifndef CFEL_DEFINES_SVH
`define CFEL_DEFINES_SVH
// Function
// - Locked data-error report kept; set lost flag.
// - Bad RMW: three check bits inverted, hard error.
// - Data-RAM hard error sets hardware transition mode.
// - Bridge returns requested quadword first.
// - Late read-error fill sets flag, lock, address.
// - Failed ownership read invalidates block, keeps data.
// - Count field holds words arrived, never 00.
// - Timeout after first word sets flag, lock.
// - Bridge parity miss sets parity, timeout flags.
// - Bridge queue overflow sets flag, hard error.
// - Unexpected fill sets flag, lock, transition mode.
// - Unexpected read-error fill also sets read-error flag.
// - Fill error while locked only sets lost.
// - Software clears flags, flushes, then clears mode.
// - Block owned once one quadword delivered.
// - Software waits write timeout before repair.
// - Hard error at priority 1D, vector 60.

// Register byte offsets on the AHB-Lite slave.
`define CFEL_OFS_DATA_ERR   8'h00
`define CFEL_OFS_FILL_ERR   8'h04
`define CFEL_OFS_FILL_ADDR  8'h08
`define CFEL_OFS_CTRL       8'h0C
`define CFEL_OFS_IRQ_STS    8'h10
`define CFEL_OFS_IRQ_CLR    8'h14
`define CFEL_OFS_IRQ_EN     8'h18
`define CFEL_OFS_DATA_ADDR  8'h1C

// Data-error status fields.
`define CFEL_DE_UNCORR      0
`define CFEL_DE_BAD_ADDR    1
`define CFEL_DE_LOST        2
`define CFEL_DE_LOCK        3
// Fill-error status fields.
`define CFEL_FE_RDE         0
`define CFEL_FE_TIMEOUT     1
`define CFEL_FE_UNEXP       2
`define CFEL_FE_LOST        3
`define CFEL_FE_LOCK        4
`define CFEL_FE_CNT_LO      5
// Control fields.
`define CFEL_CT_HW_TM       0
`define CFEL_CT_SW_TM       1
// Interrupt status bits.
`define CFEL_IRQ_DATA       0
`define CFEL_IRQ_FILL       1
`define CFEL_IRQ_UNEXP      2
`define CFEL_IRQ_LOST       3

`define CFEL_CHECK_INV      8'h07
`define CFEL_HERR_IPL       5'h1D
`define CFEL_HERR_VECTOR    12'h060
`define CFEL_LAST_WORD      3'h3
`define CFEL_CLK_MHZ        125
`define CFEL_FILL_TMO_NS    8000
`define CFEL_FILL_TMO_CYC   ((`CFEL_FILL_TMO_NS * `CFEL_CLK_MHZ) / 1000)
`endif

// file: hw/cfel_pkg.sv
package cfel_pkg;

  typedef enum logic [0:0] {RD_IDLE, RD_WAIT} cfel_rd_e;

  typedef struct packed {
    logic            hrdy;
    logic            dp;
    logic            dp_wr;
    logic [7:0]      dp_addr;
    logic [31:0]     hrdata;
    logic            de_uncorr;
    logic            de_bad_addr;
    logic            de_lost;
    logic            de_lock;
    logic [31:0]     de_addr;
    logic            fe_rde;
    logic            fe_timeout;
    logic            fe_unexp;
    logic            fe_lost;
    logic            fe_lock;
    logic [1:0]      fe_cnt;
    logic [31:0]     fe_addr;
    logic            hw_tm;
    logic            sw_tm;
    logic [3:0]      irq_sts;
    logic [3:0]      irq_en;
    logic            irq;
    logic            hard_err;
    cfel_rd_e        rd;
    logic [3:0]      tid;
    logic [31:0]     rd_addr;
    logic [2:0]      words;
    logic [15:0]     tmo;
    logic            req;
    logic            wb_valid;
    logic [7:0]      wb_check;
    logic            inval;
    logic [31:0]     inval_addr;
    logic            fw_valid;
    logic [63:0]     fw_data;
  } cfel_dev_s;

  typedef struct packed {
    logic            pend;
    logic [3:0]      tid;
    logic [31:0]     addr;
    logic [2:0]      nwords;
    logic            mem_req;
    logic            owned;
    logic            rq_ovfl;
    logic            parity;
    logic            rd_to;
    logic            hard_err;
    logic            fill_valid;
    logic [3:0]      fill_tid;
    logic            fill_rde;
    logic [63:0]     fill_data;
  } cfel_brg_s;

endpackage

// file: hw/cfel_if.sv
`timescale 1ns/10ps
interface cfel_if;
  logic        req;
  logic [3:0]  req_tid;
  logic [31:0] req_addr;
  logic        fill_valid;
  logic [3:0]  fill_tid;
  logic        fill_rde;
  logic [63:0] fill_data;

  modport dev (output req, output req_tid, output req_addr,
               input fill_valid, input fill_tid, input fill_rde, input fill_data);
  modport brg (input req, input req_tid, input req_addr,
               output fill_valid, output fill_tid, output fill_rde, output fill_data);
endinterface

// file: hw/cfel_brg.sv
`timescale 1ns/10ps
`include "cfel_defines.svh"
module cfel_brg (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  cfel_if.brg              link,
  input  wire logic        mem_valid,
  input  wire logic [63:0] mem_data,
  input  wire logic        mem_rde,
  input  wire logic        rq_full,
  input  wire logic        bus_parity_err,
  input  wire logic        flags_clear,
  output logic             mem_req,
  output logic [31:0]      mem_addr,
  output logic             blk_owned,
  output logic             rq_ovfl_flag,
  output logic             cpu_bus_parity_flag,
  output logic             read_timeout_related_flag,
  output logic             hard_err
);

  cfel_pkg::cfel_brg_s r;
  cfel_pkg::cfel_brg_s next_r;

  assign mem_req                   = r.mem_req;
  assign mem_addr                  = r.addr;
  assign blk_owned                 = r.owned;
  assign rq_ovfl_flag              = r.rq_ovfl;
  assign cpu_bus_parity_flag       = r.parity;
  assign read_timeout_related_flag = r.rd_to;
  assign hard_err                  = r.hard_err;
  assign link.fill_valid           = r.fill_valid;
  assign link.fill_tid             = r.fill_tid;
  assign link.fill_rde             = r.fill_rde;
  assign link.fill_data            = r.fill_data;

  ////////////////////////////////////////////////////////////////////////////
  // Words are forwarded in arrival order; memory starts at the requested
  // quadword, so the first fill is the one the cache asked for unless that word is dropped for overflow or parity.
  always_comb
  begin
    next_r            = r;
    next_r.mem_req    = 1'b0;
    next_r.fill_valid = 1'b0;
    if (flags_clear)
    begin
      next_r.rq_ovfl = 1'b0;
      next_r.parity  = 1'b0;
      next_r.rd_to   = 1'b0;
      next_r.owned   = 1'b0;
    end
    if (link.req)
    begin
      next_r.pend    = 1'b1;
      next_r.tid     = link.req_tid;
      next_r.addr    = link.req_addr;
      next_r.nwords  = 3'h0;
      next_r.mem_req = 1'b1;
    end
    else if (r.pend && mem_valid)
    begin
      if (rq_full)
        next_r.rq_ovfl = 1'b1;
      else if (bus_parity_err)
      begin
        next_r.parity = 1'b1;
        next_r.rd_to  = 1'b1;
      end
      else
      begin
        next_r.fill_valid = 1'b1;
        next_r.fill_tid   = r.tid;
        next_r.fill_rde   = mem_rde;
        next_r.fill_data  = mem_data;
        next_r.nwords     = r.nwords + 3'h1;
        if (!mem_rde)
          next_r.owned = 1'b1;
        if (mem_rde || r.nwords == `CFEL_LAST_WORD)
          next_r.pend = 1'b0;
      end
    end
    next_r.hard_err = next_r.rq_ovfl;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      r <= '0;
    else
      r <= next_r;
  end

endmodule // cfel_brg

// file: dv/cfel_chk.sv
`timescale 1ns/10ps
module cfel_chk (
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        req,
  input wire logic [31:0] req_addr,
  input wire logic        ownership_read_start,
  input wire logic        ownership_read_busy,
  input wire logic [31:0] ownership_read_addr,
  input wire logic        rmw_valid,
  input wire logic        rmw_uncorr,
  input wire logic        rmw_bad_addr,
  input wire logic [7:0]  rmw_check,
  input wire logic        wb_valid,
  input wire logic [7:0]  wb_check,
  input wire logic        blk_inval,
  input wire logic        error_transition_mode,
  input wire logic        hard_err_req,
  input wire logic        mem_valid,
  input wire logic        rq_full,
  input wire logic        bus_parity_err,
  input wire logic        flags_clear,
  input wire logic        mem_req,
  input wire logic        rq_ovfl_flag,
  input wire logic        cpu_bus_parity_flag,
  input wire logic        read_timeout_related_flag,
  input wire logic        hard_err
);
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  ////////////////////////////////////////////////////////////////////////////////
  sequence s_bad_rmw;
    rmw_valid && (rmw_uncorr || rmw_bad_addr);
  endsequence
  sequence s_good_rmw;
    rmw_valid && !rmw_uncorr && !rmw_bad_addr;
  endsequence
  ////////////////////////////////////////////////////////////////////////////////
  a_req_from_start: assert property (ownership_read_start && !ownership_read_busy |=> req && req_addr == $past(ownership_read_addr))
    else $error("request not issued");
  a_mem_req_follows: assert property (req |=> mem_req)
    else $error("bridge request missing");
  a_bad_rmw_inv: assert property (s_bad_rmw |=> wb_valid && wb_check == ($past(rmw_check) ^ 8'h07))
    else $error("check bits not inverted");
  a_good_rmw_clean: assert property (s_good_rmw |=> wb_valid && wb_check == $past(rmw_check))
    else $error("good check bits altered");
  a_bad_rmw_mode: assert property (s_bad_rmw |=> error_transition_mode)
    else $error("transition mode not entered");
  a_bad_rmw_herr: assert property (s_bad_rmw |-> ##[1:2] hard_err_req)
    else $error("hard error not raised");
  a_inval_state: assert property (blk_inval |-> ##[0:2] (error_transition_mode && hard_err_req))
    else $error("invalidate without error state");
  a_drop_ovfl: assert property (mem_valid && rq_full |=> rq_ovfl_flag && hard_err)
    else $error("overflow not flagged");
  a_drop_parity: assert property (mem_valid && bus_parity_err |=> cpu_bus_parity_flag && read_timeout_related_flag)
    else $error("parity miss not flagged");
  a_ovfl_sticky: assert property (rq_ovfl_flag && !flags_clear |=> rq_ovfl_flag)
    else $error("overflow flag dropped");
endmodule // cfel_chk

// file: dv/cfel_bench.sv
`timescale 1ns/10ps
module cfel_bench;
  localparam int TMO = 20;
  logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, hresp;
  logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000, hrdata, q, inval_addr, blk_inval_addr, mem_addr;
  logic [1:0]  htrans = 2'h0;
  logic        rmw_valid = 1'b0, rmw_uncorr = 1'b0, rmw_bad_addr = 1'b0, ownership_read_start = 1'b0;
  logic [31:0] rmw_addr = 32'h0000_0000, ownership_read_addr = 32'h0000_0000;
  logic [7:0]  rmw_check = 8'h00, wb_check;
  logic [3:0]  ownership_read_tid = 4'h0;
  logic        mem_valid = 1'b0, mem_rde = 1'b0, rq_full = 1'b0, bus_parity_err = 1'b0, flags_clear = 1'b0;
  logic [63:0] mem_data = 64'h0000_0000_0000_0000, fill_word, first_word;
  logic        hreadyout, wb_valid, blk_inval, fill_word_valid, ownership_read_busy, error_transition_mode, hard_err_req;
  logic        irq, mem_req, blk_owned, rq_ovfl_flag, cpu_bus_parity_flag, read_timeout_related_flag, hard_err;
  logic [4:0]  hard_err_ipl;
  logic [11:0] hard_err_vector;
  int          err_total = 0, n_compared = 0, nfill = 0, ninval = 0;
  cfel_if lnk ();
  cfel_dev #(.TMO_CYC(TMO)) cfel_dev_inst (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2),
    .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata, .rmw_valid, .rmw_uncorr, .rmw_bad_addr,
    .rmw_addr, .rmw_check, .ownership_read_start, .ownership_read_tid, .ownership_read_addr, .wb_valid, .wb_check, .blk_inval,
    .blk_inval_addr, .fill_word_valid, .fill_word, .ownership_read_busy, .error_transition_mode, .hard_err_req,
    .hard_err_ipl, .hard_err_vector, .irq, .link(lnk));
  cfel_brg cfel_brg_inst (.hclk, .hresetn, .link(lnk), .mem_valid, .mem_data, .mem_rde, .rq_full,
    .bus_parity_err, .flags_clear, .mem_req, .mem_addr, .blk_owned, .rq_ovfl_flag, .cpu_bus_parity_flag,
    .read_timeout_related_flag, .hard_err);
  cfel_chk cfel_chk_inst (.hclk, .hresetn, .req(lnk.req), .req_addr(lnk.req_addr), .ownership_read_start, .ownership_read_busy,
    .ownership_read_addr, .rmw_valid, .rmw_uncorr, .rmw_bad_addr, .rmw_check, .wb_valid, .wb_check, .blk_inval,
    .error_transition_mode, .hard_err_req, .mem_valid, .rq_full, .bus_parity_err, .flags_clear, .mem_req,
    .rq_ovfl_flag, .cpu_bus_parity_flag, .read_timeout_related_flag, .hard_err);
  always #4 hclk = ~hclk;
  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge hclk)
  begin
    if (fill_word_valid === 1'b1)
    begin
      nfill++;
      if (nfill == 1)
        first_word = fill_word;
    end
    if (blk_inval === 1'b1)
    begin
      ninval++;
      inval_addr = blk_inval_addr;
    end
  end
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e)
    begin
      err_total++;
      $display("BAD %s expected %h seen %h", s, e, g);
    end
  endtask
  // Every task starts just after a rising edge and returns just after one.
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h00_0000, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rd(input string s, input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0000_0000);
    chk(s, e, q);
    chk("hresp", 32'h0000_0000, hresp);
  endtask
  task automatic rmw(input logic u, input logic b, input logic [7:0] c, input logic [31:0] a);
    rmw_valid <= 1'b1;
    rmw_uncorr <= u;
    rmw_bad_addr <= b;
    rmw_check <= c;
    rmw_addr <= a;
    @(posedge hclk);
    rmw_valid <= 1'b0;
    @(posedge hclk);
    chk("wb_valid", 32'h0000_0001, wb_valid);
    chk("wb_check", {24'h00_0000, c ^ ((u | b) ? 8'h07 : 8'h00)}, wb_check);
  endtask
  task automatic ownership_read(input logic [3:0] t, input logic [31:0] a);
    ownership_read_start <= 1'b1;
    ownership_read_tid <= t;
    ownership_read_addr <= a;
    @(posedge hclk);
    ownership_read_start <= 1'b0;
    do @(posedge hclk); while (mem_req !== 1'b1);
    chk("mem_addr", a, mem_addr);
    chk("busy", 32'h0000_0001, ownership_read_busy);
    nfill = 0;
    ninval = 0;
  endtask
  // Released memory data is inverted so a stale word can never pass for a fresh one.
  task automatic word(input logic [63:0] d, input logic e, input logic f, input logic p);
    mem_valid <= 1'b1;
    mem_data <= d;
    mem_rde <= e;
    rq_full <= f;
    bus_parity_err <= p;
    @(posedge hclk);
    {mem_valid, mem_rde, rq_full, bus_parity_err} <= 4'h0;
    mem_data <= ~d;
    repeat (3) @(posedge hclk);
  endtask
  task automatic clr;
    wr(8'h00, 32'h0000_000F);
    wr(8'h04, 32'h0000_001F);
    wr(8'h0C, 32'h0000_0001);
    wr(8'h14, 32'h0000_000F);
    flags_clear <= 1'b1;
    @(posedge hclk);
    flags_clear <= 1'b0;
  endtask
  task automatic stop_test;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    for (int i = 0; i < 8; i++) rd("reset reg", 8'(i * 4), 32'h0000_0000);
    chk("ipl", 32'h0000_001D, hard_err_ipl);
    chk("vector", 32'h0000_0060, hard_err_vector);
    $display("test reset done");
    wr(8'h18, 32'h0000_000F);
    rmw(1'b1, 1'b0, 8'hA5, 32'h0000_1238);
    repeat (2) @(posedge hclk);
    chk("hard_err_req", 32'h0000_0001, hard_err_req);
    chk("irq", 32'h0000_0001, irq);
    rd("data status", 8'h00, 32'h0000_0009);
    rd("control", 8'h0C, 32'h0000_0001);
    rmw(1'b0, 1'b1, 8'h3C, 32'h0000_4440);
    rd("data status", 8'h00, 32'h0000_000D);
    rd("data address", 8'h1C, 32'h0000_1238);
    rd("irq status", 8'h10, 32'h0000_0009);
    wr(8'h08, 32'hFFFF_FFFF);
    rd("fill address", 8'h08, 32'h0000_0000);
    rd("unmapped", 8'h20, 32'h0000_0000);
    clr();
    rd("control", 8'h0C, 32'h0000_0000);
    chk("etm", 32'h0000_0000, error_transition_mode);
    chk("hard_err_req", 32'h0000_0000, hard_err_req);
    wr(8'h0C, 32'h0000_0002);
    rd("sw mode", 8'h0C, 32'h0000_0002);
    chk("etm sw", 32'h0000_0001, error_transition_mode);
    wr(8'h18, 32'h0000_0000);
    rmw(1'b0, 1'b1, 8'h00, 32'h0000_2000);
    rmw(1'b0, 1'b0, 8'h5A, 32'h0000_3000);
    rd("data status", 8'h00, 32'h0000_000A);
    rd("data address", 8'h1C, 32'h0000_2000);
    rd("irq status", 8'h10, 32'h0000_0001);
    chk("irq masked", 32'h0000_0000, irq);
    wr(8'h18, 32'h0000_000F);
    rd("irq status", 8'h10, 32'h0000_0001);
    chk("irq", 32'h0000_0001, irq);
    clr();
    $display("test rmw done");
    for (int k = 1; k <= 3; k++)
    begin
      ownership_read(4'h3, 32'h0008_0000 + k * 64);
      for (int w = 0; w < k; w++) word(64'hA000_0000_0000_00F0 + w, 1'b0, 1'b0, 1'b0);
      word(64'h0000_0000_0000_0000, 1'b1, 1'b0, 1'b0);
      repeat (3) @(posedge hclk);
      chk("fill words", k, nfill);
      chk("first word", 32'h0000_00F0, first_word[31:0]);
      chk("inval", 32'h0000_0001, ninval);
      chk("inval addr", 32'h0008_0000 + k * 64, inval_addr);
      chk("owned", 32'h0000_0001, blk_owned);
      rd("fill status", 8'h04, 32'h0000_0011 | (k << 5));
      rd("fill address", 8'h08, 32'h0008_0000 + k * 64);
      chk("busy", 32'h0000_0000, ownership_read_busy);
      repeat (TMO) @(posedge hclk);
      chk("owned kept", 32'h0000_0001, blk_owned);
      clr();
    end
    $display("test fill error done");
    ownership_read(4'h5, 32'h0009_0000);
    word(64'hB000_0000_0000_0001, 1'b0, 1'b0, 1'b0);
    word(64'hB000_0000_0000_0002, 1'b0, 1'b0, 1'b0);
    word(64'hB000_0000_0000_0003, 1'b0, 1'b0, 1'b1);
    chk("parity", 32'h0000_0001, cpu_bus_parity_flag);
    chk("rd timeout", 32'h0000_0001, read_timeout_related_flag);
    repeat (TMO + 10) @(posedge hclk);
    rd("fill status", 8'h04, 32'h0000_0052);
    ownership_read(4'h6, 32'h000A_0000);
    word(64'hC000_0000_0000_0001, 1'b0, 1'b0, 1'b0);
    word(64'hC000_0000_0000_0002, 1'b0, 1'b1, 1'b0);
    chk("overflow", 32'h0000_0001, hard_err);
    word(64'h0000_0000_0000_0000, 1'b1, 1'b0, 1'b0);
    rd("fill status", 8'h04, 32'h0000_005A);
    rd("fill address", 8'h08, 32'h0009_0000);
    rd("irq status", 8'h10, 32'h0000_000A);
    clr();
    $display("test timeout done");
    ownership_read(4'h7, 32'h000B_0000);
    word(64'hD000_0000_0000_0001, 1'b0, 1'b0, 1'b0);
    repeat (TMO + 10) @(posedge hclk);
    clr();
    // The bridge still holds the read that the device gave up, so this late word arrives unexpected.
    word(64'h0000_0000_0000_0000, 1'b1, 1'b0, 1'b0);
    bus(1'b0, 8'h04, 32'h0000_0000);
    chk("unexpected", 32'h0000_0015, q & 32'h0000_001F);
    chk("etm", 32'h0000_0001, error_transition_mode);
    rd("irq status", 8'h10, 32'h0000_0004);
    clr();
    $display("test unexpected done");
    stop_test();
  end
  initial
  begin
    repeat (20000) @(posedge hclk);
    err_total++;
    $display("BAD watchdog expected end seen hang");
    stop_test();
  end
endmodule // cfel_bench
